//--- logic/cpm_top.sv
/*
 * Clock source, watchdog and power mode control.
 * Assumes pins arrive asynchronously and firmware strobes are synchronous.
 */
// Behaviour
// - Three straps choose crystal or one of four external reference clocks.
// - PLL factor follows the reference so core rates never change.
// - Watchdog expiry may interrupt, wake from standby, and reset the CPU.
// - Watchdog counts a 32 kHz tick, internal or from a dedicated pin.
// - Firmware can disable the watchdog, silencing all its effects.
// - Normal mode keeps CPU clock and PLLs running.
// - Four low-power states exist besides normal mode.
// - Suspend with PHY on keeps the PHY in U3, all else gated.
// - In suspend with PHY on every pin holds its level and direction.
// - Any USB 2.0 data line change wakes from suspend with PHY on.
// - Suspend entry comes from firmware or an external mailbox write.
// - Resume, VBUS, CTS level, control line zero or reset pin also wake.
// - Waking other than by the reset pin or a watchdog expiry with reset enabled leaves the CPU running on.
`timescale 1ns/1ns
module cpm_top
	import cpm_pkg::*;
#(
	parameter int IO_W = 8
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic resetn,
	// Straps and slow clock pin.
	input wire logic [2:0] ref_freq_select_straps,
	input wire logic slow_watchdog_clock_pin,
	input wire logic slow_ext_select,
	// Reference configuration.
	output logic use_crystal,
	output logic [2:0] ref_select,
	output logic [7:0] pll_mult,
	output logic straps_valid,
	// Watchdog control.
	input wire cpm_wdt_cfg_t wdt_cfg,
	input wire logic wdt_kick,
	input wire logic wdt_irq_clear,
	output logic wdt_irq,
	output logic cpu_reset,
	// Power mode requests.
	input wire logic fw_enter_req,
	input wire cpm_mode_t fw_target_mode,
	input wire logic mailbox_suspend_req,
	// Wake sources.
	input wire logic usb_dp,
	input wire logic usb_dm,
	input wire cpm_wake_t wake_pins,
	input wire logic cts_wake_polarity,
	input wire logic hard_reset_pin_n,
	// Clock and power controls.
	output cpm_mode_t mode,
	output logic cpu_clk_en,
	output logic pll_en,
	output logic periph_clk_en,
	output logic phy_en,
	output logic phy_u3,
	output logic core_power_off,
	output logic io_hold,
	output logic wake_event,
	// Pin retention.
	input wire logic [IO_W-1:0] io_out_live,
	input wire logic [IO_W-1:0] io_oe_live,
	output logic [IO_W-1:0] io_out,
	output logic [IO_W-1:0] io_oe
);

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	localparam int SW = 11;

	logic [SW-1:0] pins_raw;
	logic [SW-1:0] pins_s;
	logic [2:0] straps_s;
	logic slow_s;
	logic dp_s;
	logic dm_s;
	logic rst_pin_n_s;
	cpm_wake_t wake_s;

	assign pins_raw = {ref_freq_select_straps, slow_watchdog_clock_pin,
		usb_dp, usb_dm, hard_reset_pin_n, wake_pins};

	cpm_sync #(.WIDTH(SW)) u_sync (
		.clk(clk),
		.resetn(resetn),
		.din(pins_raw),
		.dout(pins_s)
	);

	assign straps_s = pins_s[10:8];
	assign slow_s = pins_s[7];
	assign dp_s = pins_s[6];
	assign dm_s = pins_s[5];
	assign rst_pin_n_s = pins_s[4];
	assign wake_s = pins_s[3:0];

	// ---------------------------------------------------------------
	// Strap capture and PLL factor
	// ---------------------------------------------------------------
	logic [1:0] settle;

	// Waiting lets the synchroniser fill before the straps are taken.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			settle <= 2'h0;
		end else if (settle != CPM_STRAP_SETTLE) begin
			settle <= settle + 2'h1;
		end
	end

	// Straps are frozen once; later pin changes are ignored.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			straps_valid <= 1'b0;
			ref_select <= CPM_SEL_XTAL_19M2;
			use_crystal <= 1'b1;
			pll_mult <= CPM_MULT_19M2;
		end else if (!straps_valid && settle == CPM_STRAP_SETTLE) begin
			straps_valid <= 1'b1;
			ref_select <= straps_s;
			use_crystal <= (straps_s == CPM_SEL_XTAL_19M2);
			case (straps_s)
				CPM_SEL_XTAL_19M2,
				CPM_SEL_CLK_19M2: pll_mult <= CPM_MULT_19M2;
				CPM_SEL_CLK_26M: pll_mult <= CPM_MULT_26M;
				CPM_SEL_CLK_38M4: pll_mult <= CPM_MULT_38M4;
				CPM_SEL_CLK_52M: pll_mult <= CPM_MULT_52M;
				// Unlisted codes fall back to the crystal setting.
				default: begin
					use_crystal <= 1'b1;
					pll_mult <= CPM_MULT_19M2;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Slow watchdog tick
	// ---------------------------------------------------------------
	localparam int DW = $clog2(CPM_SLOW_DIV);
	localparam logic [DW-1:0] DIV_LAST = DW'(CPM_SLOW_DIV - 1);

	logic [DW-1:0] div_cnt;
	logic int_tick;
	logic slow_prev;
	logic ext_tick;
	logic slow_tick;

	// Internal source: divide the system clock down to 32 kHz.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			div_cnt <= '0;
			int_tick <= 1'b0;
		end else begin
			int_tick <= (div_cnt == DIV_LAST);
			div_cnt <= (div_cnt == DIV_LAST) ? '0 : div_cnt + 1'b1;
		end
	end

	// External source: rising edges of the synchronised pin.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			slow_prev <= 1'b0;
		end else begin
			slow_prev <= slow_s;
		end
	end

	assign ext_tick = slow_s && !slow_prev;
	assign slow_tick = slow_ext_select ? ext_tick : int_tick;

	// ---------------------------------------------------------------
	// Watchdog
	// ---------------------------------------------------------------
	logic wdt_expire;
	logic wdt_fire;

	// The counter keeps running in every state so it can wake standby.
	cpm_wdt u_wdt (
		.clk(clk),
		.resetn(resetn),
		.tick(slow_tick),
		.enable(wdt_cfg.enable),
		.kick(wdt_kick),
		.load(wdt_cfg.load),
		.count(),
		.expire(wdt_expire)
	);

	assign wdt_fire = wdt_expire && wdt_cfg.enable;

	// Interrupt flag: a new expiry beats a clear in the same cycle.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wdt_irq <= 1'b0;
		end else if (!wdt_cfg.enable) begin
			wdt_irq <= 1'b0;
		end else if (wdt_fire && wdt_cfg.irq_en) begin
			wdt_irq <= 1'b1;
		end else if (wdt_irq_clear) begin
			wdt_irq <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Wake detection
	// ---------------------------------------------------------------
	logic dp_prev;
	logic dm_prev;
	logic rst_pin_prev_n;
	logic line_wake;
	logic pin_wake;
	logic reset_wake;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dp_prev <= 1'b0;
			dm_prev <= 1'b0;
			rst_pin_prev_n <= 1'b0; // Matches the flop, so no false fall.
		end else begin
			dp_prev <= dp_s;
			dm_prev <= dm_s;
			rst_pin_prev_n <= rst_pin_n_s;
		end
	end

	// Either edge wakes, but only once the synchronisers have filled.
	assign line_wake = (settle == CPM_STRAP_SETTLE)
		&& ((dp_s != dp_prev) || (dm_s != dm_prev));
	assign pin_wake = wake_s.ssrx_resume || wake_s.vbus
		|| (wake_s.cts == cts_wake_polarity)
		|| wake_s.parallel_port_control_line_zero;
	assign reset_wake = rst_pin_prev_n && !rst_pin_n_s;

	// ---------------------------------------------------------------
	// Power mode state machine
	// ---------------------------------------------------------------
	cpm_mode_t next_mode;
	logic next_wake;

	always_comb begin
		next_mode = mode;
		next_wake = 1'b0;
		case (mode)
			CPM_NORMAL: begin
				if (mailbox_suspend_req) begin
					next_mode = CPM_SUSPEND_PHY_ON;
				end else if (fw_enter_req) begin
					next_mode = fw_target_mode;
				end
			end
			CPM_SUSPEND_PHY_ON,
			CPM_SUSPEND_PHY_OFF: begin
				next_wake = line_wake || pin_wake || reset_wake;
			end
			CPM_STANDBY: begin
				next_wake = line_wake || pin_wake || reset_wake
					|| (wdt_fire && wdt_cfg.wake_en);
			end
			CPM_CORE_POWER_DOWN: begin
				// Core state is lost, so only the reset pin or VBUS revive it.
				next_wake = reset_wake || wake_s.vbus;
			end
			default: begin
				next_mode = CPM_NORMAL;
			end
		endcase
		if (next_wake) begin
			next_mode = CPM_NORMAL;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mode <= CPM_NORMAL;
			wake_event <= 1'b0;
		end else begin
			mode <= next_mode;
			wake_event <= next_wake;
		end
	end

	// CPU reset pulse: reset-pin wakes and enabled watchdog expiry only.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cpu_reset <= 1'b0;
		end else begin
			cpu_reset <= (next_wake && reset_wake)
				|| (wdt_fire && wdt_cfg.reset_en);
		end
	end

	// ---------------------------------------------------------------
	// Clock gating and power controls
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cpu_clk_en <= 1'b1;
			pll_en <= 1'b1;
			periph_clk_en <= 1'b1;
			phy_en <= 1'b1;
			phy_u3 <= 1'b0;
			core_power_off <= 1'b0;
		end else begin
			cpu_clk_en <= (next_mode == CPM_NORMAL);
			pll_en <= (next_mode == CPM_NORMAL);
			periph_clk_en <= (next_mode == CPM_NORMAL);
			phy_en <= (next_mode == CPM_NORMAL)
				|| (next_mode == CPM_SUSPEND_PHY_ON);
			phy_u3 <= (next_mode == CPM_SUSPEND_PHY_ON);
			core_power_off <= (next_mode == CPM_CORE_POWER_DOWN);
		end
	end

	// ---------------------------------------------------------------
	// Pin retention
	// ---------------------------------------------------------------
	// Pins are frozen on entry; the live values are not sampled again
	// until normal mode returns, so late firmware writes reach the pins only then.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			io_hold <= 1'b0;
			io_out <= '0;
			io_oe <= '0;
		end else begin
			io_hold <= (next_mode != CPM_NORMAL);
			if (next_mode == CPM_NORMAL) begin
				io_out <= io_out_live;
				io_oe <= io_oe_live;
			end
		end
	end

endmodule

//--- logic/cpm_pkg.sv
/*
 * Shared constants and carrier types for the clock and power mode block.
 * Assumes a single 100 MHz system clock and straps that are stable at reset.
 */
package cpm_pkg;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CPM_CLK_HZ = 100_000_000;
	localparam int CPM_SLOW_HZ = 32_000;
	// Internal slow tick divider, never a longer period so rounded down.
	localparam int CPM_SLOW_DIV = CPM_CLK_HZ / CPM_SLOW_HZ;
	// Cycles after reset release before the straps are taken.
	localparam logic [1:0] CPM_STRAP_SETTLE = 2'h3;

	// ---------------------------------------------------------------
	// Strap codes
	// ---------------------------------------------------------------
	localparam logic [2:0] CPM_SEL_XTAL_19M2 = 3'h0;
	localparam logic [2:0] CPM_SEL_CLK_19M2 = 3'h4;
	localparam logic [2:0] CPM_SEL_CLK_26M = 3'h5;
	localparam logic [2:0] CPM_SEL_CLK_38M4 = 3'h6;
	localparam logic [2:0] CPM_SEL_CLK_52M = 3'h7;

	// PLL factors giving one 2496 MHz VCO rate from every reference.
	localparam logic [7:0] CPM_MULT_19M2 = 8'h82;
	localparam logic [7:0] CPM_MULT_26M = 8'h60;
	localparam logic [7:0] CPM_MULT_38M4 = 8'h41;
	localparam logic [7:0] CPM_MULT_52M = 8'h30;

	// ---------------------------------------------------------------
	// Power states
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		CPM_NORMAL,
		CPM_SUSPEND_PHY_ON,
		CPM_SUSPEND_PHY_OFF,
		CPM_STANDBY,
		CPM_CORE_POWER_DOWN
	} cpm_mode_t;

	// ---------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------
	localparam int CPM_WDT_W = 16;
	localparam logic [CPM_WDT_W-1:0] CPM_WDT_LOAD_RST = 16'hFFFF;

	typedef struct packed {
		logic enable;
		logic irq_en;
		logic wake_en;
		logic reset_en;
		logic [CPM_WDT_W-1:0] load;
	} cpm_wdt_cfg_t;

	// Wake inputs other than the USB 2.0 data lines and the reset pin.
	typedef struct packed {
		logic ssrx_resume;
		logic vbus;
		logic cts;
		logic parallel_port_control_line_zero;
	} cpm_wake_t;

endpackage

//--- logic/cpm_sync.sv
/*
 * Two-flop synchroniser for a bus of independent levels.
 * Assumes each bit is an unrelated level; no word coherence is given.
 */
`timescale 1ns/1ns
module cpm_sync
	import cpm_pkg::*;
#(
	parameter int WIDTH = 1
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic resetn,
	// Levels.
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] meta;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta <= '0;
			dout <= '0;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end

endmodule

//--- logic/cpm_wdt.sv
/*
 * Watchdog down counter advanced by a slow tick enable.
 * Assumes tick is a one-cycle pulse on the system clock.
 */
`timescale 1ns/1ns
module cpm_wdt
	import cpm_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic resetn,
	// Control.
	input wire logic tick,
	input wire logic enable,
	input wire logic kick,
	input wire logic [CPM_WDT_W-1:0] load,
	// Status.
	output logic [CPM_WDT_W-1:0] count,
	output logic expire
);

	// A disabled counter sits at the load value, so it cannot expire.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			count <= CPM_WDT_LOAD_RST;
			expire <= 1'b0;
		end else begin
			expire <= 1'b0;
			if (!enable || kick) begin
				count <= load;
			end else if (tick) begin
				if (count == '0) begin
					expire <= 1'b1;
					count <= load;
				end else begin
					count <= count - 1'b1;
				end
			end
		end
	end

endmodule

//--- verification/cpm_far_model.sv
/*
 * Far-side model: slow watchdog clock source and wake signalling pins.
 * Assumes the bench calls its tasks between clock edges.
 */
`timescale 1ns/1ns
module cpm_far_model
	import cpm_pkg::*;
#(
	parameter int HALF_NS = 200
) (
	// Pins driven towards the block.
	output logic slow_watchdog_clock_pin,
	output logic usb_dp,
	output logic usb_dm,
	output cpm_wake_t wake_pins
);
	// The oscillator runs free; it is scaled up so that ticks come often.
	initial slow_watchdog_clock_pin = 1'b0;
	always #(HALF_NS) slow_watchdog_clock_pin = ~slow_watchdog_clock_pin;

	// The data lines idle in the J state and the wake levels idle low.
	initial begin
		usb_dp = 1'b1;
		usb_dm = 1'b0;
		wake_pins = '0;
	end

	// Fire one source: 0 dp, 1 dm, 2 resume, 3 vbus, 4 cts, 5 line zero.
	task automatic poke(input int k);
		case (k)
			0: usb_dp = ~usb_dp;
			1: usb_dm = ~usb_dm;
			2: wake_pins.ssrx_resume = 1'b1;
			3: wake_pins.vbus = 1'b1;
			4: wake_pins.cts = 1'b1;
			default: wake_pins.parallel_port_control_line_zero = 1'b1;
		endcase
	endtask

	// Level sources must drop again, or they would wake the next suspend.
	task automatic calm();
		wake_pins = '0;
	endtask
endmodule

//--- verification/cpm_top_asserts.sv
/*
 * Concurrent checks on the clock and power mode block ports.
 * Assumes it is bound to every cpm_top instance.
 */
`timescale 1ns/1ns
module cpm_top_asserts
	import cpm_pkg::*;
#(
	parameter int IO_W = 8
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic resetn,
	// Observed ports.
	input wire logic [2:0] ref_select,
	input wire logic [7:0] pll_mult,
	input wire logic straps_valid,
	input wire cpm_wdt_cfg_t wdt_cfg,
	input wire logic wdt_irq,
	input wire logic fw_enter_req,
	input wire cpm_mode_t fw_target_mode,
	input wire logic mailbox_suspend_req,
	input wire logic usb_dp,
	input wire cpm_mode_t mode,
	input wire logic cpu_clk_en,
	input wire logic pll_en,
	input wire logic phy_en,
	input wire logic phy_u3,
	input wire logic io_hold,
	input wire logic wake_event,
	input wire logic [IO_W-1:0] io_out,
	input wire logic [IO_W-1:0] io_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	// Factor that keeps one VCO rate; unlisted codes fall back to crystal.
	function automatic logic [7:0] mult(input logic [2:0] s);
		case (s)
			CPM_SEL_CLK_26M: return CPM_MULT_26M;
			CPM_SEL_CLK_38M4: return CPM_MULT_38M4;
			CPM_SEL_CLK_52M: return CPM_MULT_52M;
			default: return CPM_MULT_19M2;
		endcase
	endfunction

	// A data line change seen while suspended with the PHY on.
	sequence s_dp_edge;
		mode == CPM_SUSPEND_PHY_ON && $changed(usb_dp);
	endsequence
	sequence s_woken;
		##[1:4] wake_event;
	endsequence

	chk_pll_factor: assert property (straps_valid |-> pll_mult == mult(ref_select))
		else $error("pll factor does not match strap code");
	chk_straps_held: assert property (straps_valid && $past(straps_valid) |-> $stable({ref_select, pll_mult}))
		else $error("reference configuration changed");
	chk_clock_gate: assert property (cpu_clk_en == (mode == CPM_NORMAL) && pll_en == cpu_clk_en)
		else $error("core clocks wrong for mode");
	chk_phy_suspend: assert property (mode == CPM_SUSPEND_PHY_ON |-> phy_en && phy_u3)
		else $error("phy not kept in suspend");
	chk_io_frozen: assert property (io_hold && $past(io_hold) |-> $stable({io_out, io_oe}))
		else $error("pins moved while held");
	chk_dp_wake: assert property (s_dp_edge |-> s_woken)
		else $error("no wake after data line change");
	chk_wake_normal: assert property (wake_event |-> mode == CPM_NORMAL && !io_hold && $past(mode) != CPM_NORMAL)
		else $error("wake pulse without return to normal");
	chk_wdt_off: assert property (!wdt_cfg.enable |=> !wdt_irq)
		else $error("disabled watchdog interrupt");
	chk_fw_enter: assert property (mode == CPM_NORMAL && fw_enter_req && !mailbox_suspend_req && fw_target_mode == CPM_STANDBY |=> mode == CPM_STANDBY)
		else $error("standby request not taken");
	chk_mbox_enter: assert property (mode == CPM_NORMAL && mailbox_suspend_req |=> mode == CPM_SUSPEND_PHY_ON)
		else $error("mailbox suspend not taken");
endmodule

bind cpm_top cpm_top_asserts #(.IO_W(IO_W)) u_chk (
	.clk(clk), .resetn(resetn), .ref_select(ref_select),
	.pll_mult(pll_mult), .straps_valid(straps_valid), .wdt_cfg(wdt_cfg),
	.wdt_irq(wdt_irq), .fw_enter_req(fw_enter_req),
	.fw_target_mode(fw_target_mode),
	.mailbox_suspend_req(mailbox_suspend_req), .usb_dp(usb_dp),
	.mode(mode), .cpu_clk_en(cpu_clk_en), .pll_en(pll_en),
	.phy_en(phy_en), .phy_u3(phy_u3), .io_hold(io_hold),
	.wake_event(wake_event), .io_out(io_out), .io_oe(io_oe)
);

//--- verification/cpm_top_tb_top.sv
/*
 * Self-checking bench for the clock and power mode block.
 * Assumes the far-side model supplies the slow clock and wake pins.
 */
`timescale 1ns/1ns
module cpm_top_tb_top
	import cpm_pkg::*;
;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	logic clk = 1'b0, resetn = 1'b0, dp, dm, slow_pin;
	logic [2:0] straps = 3'h0;
	logic slow_ext_select = 1'b1, wdt_kick = 1'b0, wdt_irq_clear = 1'b0;
	logic fw_enter_req = 1'b0, mailbox_suspend_req = 1'b0;
	logic hard_reset_pin_n = 1'b1;
	cpm_wdt_cfg_t wdt_cfg = '0;
	cpm_mode_t fw_target_mode = CPM_NORMAL, mode;
	cpm_wake_t wake_pins;
	logic [7:0] io_out_live = 8'h00, io_oe_live = 8'h00, io_out, io_oe;
	logic [7:0] pll_mult, live_out, live_oe;
	logic [2:0] ref_sel;
	logic periph_clk_en, cts_pol = 1'b1;
	logic use_crystal, straps_valid, wdt_irq, cpu_reset, irq_q;
	logic cpu_clk_en, pll_en, phy_en, phy_u3, core_power_off, io_hold;
	logic wake_event;
	int num_errors, n_compared, n_wake, n_rst, n_irq, r0, cyc;

	always #5 clk = ~clk;

	cpm_far_model u_far (.slow_watchdog_clock_pin(slow_pin), .usb_dp(dp),
		.usb_dm(dm), .wake_pins(wake_pins));

	cpm_top u_dut (.clk(clk), .resetn(resetn), .ref_freq_select_straps(straps),
		.slow_watchdog_clock_pin(slow_pin), .slow_ext_select(slow_ext_select),
		.use_crystal(use_crystal), .ref_select(ref_sel), .pll_mult(pll_mult),
		.straps_valid(straps_valid), .wdt_cfg(wdt_cfg), .wdt_kick(wdt_kick),
		.wdt_irq_clear(wdt_irq_clear), .wdt_irq(wdt_irq), .cpu_reset(cpu_reset),
		.fw_enter_req(fw_enter_req), .fw_target_mode(fw_target_mode),
		.mailbox_suspend_req(mailbox_suspend_req), .usb_dp(dp), .usb_dm(dm),
		.wake_pins(wake_pins), .cts_wake_polarity(cts_pol),
		.hard_reset_pin_n(hard_reset_pin_n), .mode(mode),
		.cpu_clk_en(cpu_clk_en), .pll_en(pll_en),
		.periph_clk_en(periph_clk_en),
		.phy_en(phy_en), .phy_u3(phy_u3), .core_power_off(core_power_off),
		.io_hold(io_hold), .wake_event(wake_event), .io_out_live(io_out_live),
		.io_oe_live(io_oe_live), .io_out(io_out), .io_oe(io_oe));

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// Event counters let waits end on any pulse without missing one.
	always @(posedge clk) begin
		n_wake += (wake_event === 1'b1);
		n_rst += (cpu_reset === 1'b1);
		n_irq += (wdt_irq === 1'b1 && irq_q !== 1'b1);
		irq_q <= wdt_irq;
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			finish_test();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	function automatic logic [7:0] exp_mult(input logic [2:0] s);
		case (s)
			3'h5: return CPM_MULT_26M;
			3'h6: return CPM_MULT_38M4;
			3'h7: return CPM_MULT_52M;
			default: return CPM_MULT_19M2;
		endcase
	endfunction

	task automatic rst(input logic [2:0] s);
		resetn = 1'b0;
		straps = s;
		repeat (3) @(negedge clk);
		resetn = 1'b1;
		repeat (6) @(negedge clk);
	endtask

	task automatic req(input logic mb, input cpm_mode_t m);
		mailbox_suspend_req = mb;
		fw_enter_req = ~mb;
		fw_target_mode = m;
		@(negedge clk);
		mailbox_suspend_req = 1'b0;
		fw_enter_req = 1'b0;
	endtask

	task automatic await(input int lim);
		int s;
		s = n_wake + n_rst + n_irq;
		for (int i = 0; i < lim && s == n_wake + n_rst + n_irq; i++)
			@(negedge clk);
		repeat (3) @(negedge clk);
	endtask

	task automatic pulse_kick();
		wdt_kick = 1'b1;
		@(negedge clk);
		wdt_kick = 1'b0;
	endtask

	task automatic finish_test();
		$display("compared=%0d errors=%0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial begin
		void'($urandom(40517));
		// Every strap code, then a late change that must be ignored.
		for (int i = 0; i < 8; i++) begin
			rst(i[2:0]);
			chk({straps_valid, use_crystal, ref_sel, pll_mult},
				{1'b1, i < 4, i[2:0], exp_mult(i[2:0])});
			straps = ~i[2:0];
			repeat (3) @(negedge clk);
			chk(pll_mult, exp_mult(i[2:0]));
		end
		$display("test straps done");
		// Each wake source but the reset pin, from suspend with the PHY on.
		for (int k = 0; k < 6; k++) begin
			live_out = 8'($urandom);
			live_oe = 8'($urandom);
			io_out_live = live_out;
			io_oe_live = live_oe;
			@(negedge clk);
			req(k[0], CPM_SUSPEND_PHY_ON);
			chk({mode, cpu_clk_en, pll_en, periph_clk_en,
				phy_en, phy_u3, io_hold}, {CPM_SUSPEND_PHY_ON, 6'b000111});
			io_out_live = 8'($urandom);
			io_oe_live = ~live_oe;
			@(negedge clk);
			req(1'b0, CPM_STANDBY);
			chk(mode, CPM_SUSPEND_PHY_ON);
			chk({io_out, io_oe}, {live_out, live_oe});
			u_far.poke(k);
			await(10);
			chk({mode, cpu_clk_en, io_hold}, {CPM_NORMAL, 2'b10});
			u_far.calm();
			chk(io_oe, io_oe_live);
		end
		// Clear-to-send wake with the low polarity: the level drop wakes.
		cts_pol = 1'b0;
		@(negedge clk);
		u_far.poke(4);
		repeat (3) @(negedge clk);
		req(1'b0, CPM_SUSPEND_PHY_ON);
		chk(mode, CPM_SUSPEND_PHY_ON);
		u_far.calm();
		await(10);
		chk(mode, CPM_NORMAL);
		cts_pol = 1'b1;
		$display("test wake done");
		// Remaining states; reset pin and vbus as wake sources.
		for (int m = 2; m < 5; m++) begin
			r0 = n_rst;
			req(1'b0, cpm_mode_t'(m));
			chk({mode, cpu_clk_en, pll_en, periph_clk_en,
				phy_en, phy_u3, core_power_off, io_hold},
				{m[2:0], 5'b00000, m == 4, 1'b1});
			if (m == 4) begin
				u_far.poke(0);
				repeat (8) @(negedge clk);
				chk(mode, CPM_CORE_POWER_DOWN);
				u_far.poke(3);
			end else if (m == 3)
				hard_reset_pin_n = 1'b0;
			else
				u_far.poke(1);
			await(10);
			chk({mode, 8'(n_rst - r0)}, {CPM_NORMAL, 8'(m == 3)});
			hard_reset_pin_n = 1'b1;
			u_far.calm();
		end
		$display("test modes done");
		// Watchdog from the pin: interrupt, CPU reset, wake from standby.
		wdt_cfg = '{1'b1, 1'b1, 1'b1, 1'b1, 16'h0002};
		pulse_kick();
		r0 = n_rst;
		await(400);
		chk({wdt_irq, 8'(n_rst - r0)}, 9'h101);
		wdt_irq_clear = 1'b1;
		@(negedge clk);
		wdt_irq_clear = 1'b0;
		chk(wdt_irq, 1'b0);
		req(1'b0, CPM_STANDBY);
		await(400);
		chk(mode, CPM_NORMAL);
		// Disabled watchdog must stay silent in standby.
		wdt_cfg.enable = 1'b0;
		r0 = n_rst;
		req(1'b0, CPM_STANDBY);
		repeat (300) @(negedge clk);
		chk({mode, wdt_irq, 8'(n_rst - r0)}, {CPM_STANDBY, 9'h000});
		u_far.poke(0);
		await(10);
		// Internal divider as the slow tick source.
		slow_ext_select = 1'b0;
		wdt_cfg = '{1'b1, 1'b1, 1'b0, 1'b0, 16'h0000};
		pulse_kick();
		await(7000);
		chk(wdt_irq, 1'b1);
		$display("test watchdog done");
		finish_test();
	end
endmodule
